// [verilog/mm_master_pkg.sv]
// constants and types shared by the memory-mapped master port
package mm_master_pkg;
  // ****************************************
  // port geometry limits
  // ****************************************
  localparam int ADDR_W_DEF = 32;
  localparam int ADDR_W_MIN = 1;
  localparam int ADDR_W_MAX = 32;
  localparam int DATA_W_DEF = 32;
  localparam int DATA_W_MIN = 8;
  localparam int DATA_W_MAX = 1024;
  localparam int BE_W_MAX   = 128;
  // ****************************************
  // field widths
  // ****************************************
  // log2 of access size in bytes, 0..7
  localparam int SIZE_W = 3;
  // byte offset / byte count width, holds up to 511
  localparam int CNT_W  = 9;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic RST_REQ   = 1'b0;
  localparam logic RST_READY = 1'b1;
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b01,
    ST_ACCESS = 2'b10
  } state_t;
endpackage : mm_master_pkg

// [verilog/lane_if.sv]
// carrier between the sequencer and the byte-lane encoder
`timescale 1ns/10ps
interface lane_if #(
  parameter int ADDR_W = mm_master_pkg::ADDR_W_DEF,
  parameter int DATA_W = mm_master_pkg::DATA_W_DEF
);
  localparam int BE_W = DATA_W / 8;
  logic [ADDR_W-1:0]                      addr;
  logic [mm_master_pkg::SIZE_W-1:0]       size;
  logic [DATA_W-1:0]                      wdata;
  logic [ADDR_W-1:0]                      word_addr;
  logic [BE_W-1:0]                        be;
  logic [DATA_W-1:0]                      lane_wdata;
  logic [mm_master_pkg::CNT_W-1:0]        off;
  logic                                   legal;
  modport enc  (input addr, size, wdata, output word_addr, be, lane_wdata, off, legal);
  modport user (output addr, size, wdata, input word_addr, be, lane_wdata, off, legal);
endinterface : lane_if

// [verilog/lane_encoder.sv]
// maps a byte request onto an aligned word address and byte-lane selects
`timescale 1ns/10ps
module lane_encoder #(
  parameter int ADDR_W = mm_master_pkg::ADDR_W_DEF,
  parameter int DATA_W = mm_master_pkg::DATA_W_DEF
) (
  // request and encoded result
  lane_if.enc lanes
);
  localparam int BE_W = DATA_W / 8;
  localparam int LSB  = $clog2(BE_W);
  localparam int CW   = mm_master_pkg::CNT_W;

  // ****************************************
  // offset, byte count, legality
  // ****************************************
  wire [31:0]   addr_ext = 32'(lanes.addr);
  wire [31:0]   lane_msk = 32'(BE_W - 1);
  wire [CW-1:0] off      = CW'(addr_ext & lane_msk);
  wire [CW-1:0] nbytes   = CW'(1) << lanes.size;
  wire [CW-1:0] lim      = CW'(off + nbytes);
  // RQ10 power-of-two group, size-aligned
  wire          fits     = (32'(lanes.size) <= 32'(LSB));
  wire          aligned  = ((off & CW'(nbytes - CW'(1))) == '0);

  assign lanes.off   = off;
  assign lanes.legal = fits && aligned;
  // RQ2 word address aligned to port width
  assign lanes.word_addr = ADDR_W'(addr_ext & ~lane_msk);
  // RQ9 data moved onto its selected lanes
  assign lanes.lane_wdata = DATA_W'(lanes.wdata << {off, 3'b000});

  // ****************************************
  // per-lane select
  // ****************************************
  // RQ8 bit n selects byte lane n
  for (genvar i = 0; i < BE_W; i++) begin : g_lane
    // RQ11 adjacent lanes only, e.g. 0011 or 1100
    assign lanes.be[i] = lanes.legal && (CW'(i) >= off) && (CW'(i) < lim);
  end
endmodule : lane_encoder

// [verilog/mm_master_port.sv]
// memory-mapped bus master port: fundamental address, request, data, lane signals
// Behaviour
// RQ1 - byte address output, 1 to 32 bits
// RQ2 - addresses aligned to own data width
// RQ3 - fabric turns byte address into word
// RQ4 - read request output with read data input
// RQ5 - write request output with write data
// RQ6 - data width 8 to 1024, power of two
// RQ7 - read and write data same width
// RQ8 - lane select bit n for byte n
// RQ9 - lane selects mark bytes written or read
// RQ10 - selected lanes adjacent, power-of-two, aligned
// RQ11 - 32-bit legal patterns: full, halves, bytes
// RQ12 - hold control outputs while stalled
// RQ13 - 32-bit master uses 4-byte boundaries
// RQ14 - never read and write together
`timescale 1ns/10ps
module mm_master_port #(
  parameter int ADDR_W = mm_master_pkg::ADDR_W_DEF,
  parameter int DATA_W = mm_master_pkg::DATA_W_DEF
) (
  // clock and reset
  input  wire logic                              i_clk,
  input  wire logic                              i_rst_n,
  // user command
  input  wire logic                              i_cmd_valid,
  input  wire logic                              i_cmd_write,
  input  wire logic [ADDR_W-1:0]                 i_cmd_addr,
  input  wire logic [mm_master_pkg::SIZE_W-1:0]  i_cmd_size,
  input  wire logic [DATA_W-1:0]                 i_cmd_wdata,
  output logic                                   o_cmd_ready,
  // user response
  output logic                                   o_rsp_valid,
  output logic                                   o_rsp_err,
  output logic [DATA_W-1:0]                      o_rsp_rdata,
  // bus side
  output logic [ADDR_W-1:0]                      o_address,
  output logic                                   o_read,
  output logic                                   o_write,
  output logic [DATA_W-1:0]                      o_writedata,
  output logic [DATA_W/8-1:0]                    o_byteenable,
  input  wire logic [DATA_W-1:0]                 i_readdata,
  input  wire logic                              i_waitrequest
);
  localparam int BE_W = DATA_W / 8;
  localparam int CW   = mm_master_pkg::CNT_W;
  localparam int RD_W = DATA_W;
  localparam int WR_W = DATA_W;

  // ****************************************
  // elaboration checks
  // ****************************************
  // RQ1 address width range
  if (ADDR_W < mm_master_pkg::ADDR_W_MIN || ADDR_W > mm_master_pkg::ADDR_W_MAX) begin : g_bad_addr
    $error("address width out of range");
  end
  // RQ6 data width 8 to 1024
  if (DATA_W < mm_master_pkg::DATA_W_MIN || DATA_W > mm_master_pkg::DATA_W_MAX ||
      (DATA_W & (DATA_W - 1)) != 0) begin : g_bad_data
    $error("data width must be a power of two from 8 to 1024");
  end
  // RQ7 read and write widths equal
  if (RD_W != WR_W) begin : g_bad_pair
    $error("read and write data widths differ");
  end
  if (BE_W > mm_master_pkg::BE_W_MAX || $clog2(BE_W) > (1 << mm_master_pkg::SIZE_W) - 1) begin : g_bad_be
    $error("lane select width unsupported");
  end
  if (ADDR_W < $clog2(BE_W)) begin : g_bad_span
    $error("address too narrow for data width");
  end

  // ****************************************
  // lane encoder
  // ****************************************
  lane_if #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) lanes ();

  assign lanes.addr  = i_cmd_addr;
  assign lanes.size  = i_cmd_size;
  assign lanes.wdata = i_cmd_wdata;

  lane_encoder #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_enc (
    .lanes (lanes.enc)
  );

  // ****************************************
  // state and registers
  // ****************************************
  mm_master_pkg::state_t state_q;
  mm_master_pkg::state_t state_d;
  logic [ADDR_W-1:0]     addr_q;
  logic                  read_q;
  logic                  read_d;
  logic                  write_q;
  logic                  write_d;
  logic [WR_W-1:0]       wdata_q;
  logic [BE_W-1:0]       be_q;
  logic [CW-1:0]         off_q;
  logic                  ready_q;
  logic                  ready_d;
  logic                  rsp_valid_q;
  logic                  rsp_err_q;
  logic [RD_W-1:0]       rdata_q;

  // ****************************************
  // decode
  // ****************************************
  wire take      = i_cmd_valid && ready_q;
  wire launch    = take && lanes.legal;
  wire refuse    = take && !lanes.legal;
  wire in_access = (state_q == mm_master_pkg::ST_ACCESS);
  // RQ12 access ends only when stall is low
  wire done      = in_access && !i_waitrequest;
  wire got_read  = done && read_q;
  // RQ4 read data lanes moved back to bit 0
  wire [DATA_W-1:0] rd_shift = DATA_W'(i_readdata >> {off_q, 3'b000});

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      mm_master_pkg::ST_IDLE: begin
        if (launch) begin
          state_d = mm_master_pkg::ST_ACCESS;
        end
      end
      mm_master_pkg::ST_ACCESS: begin
        if (done) begin
          state_d = mm_master_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = mm_master_pkg::ST_IDLE;
      end
    endcase
  end

  // RQ14 one command gives read or write, never both
  assign read_d  = launch ? !i_cmd_write : (done ? 1'b0 : read_q);
  assign write_d = launch ? i_cmd_write : (done ? 1'b0 : write_q);
  // ready returns the cycle after completion
  assign ready_d = (state_d == mm_master_pkg::ST_IDLE);

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= mm_master_pkg::ST_IDLE;
      read_q  <= mm_master_pkg::RST_REQ;
      write_q <= mm_master_pkg::RST_REQ;
      ready_q <= mm_master_pkg::RST_READY;
    end else begin
      state_q <= state_d;
      read_q  <= read_d;
      write_q <= write_d;
      ready_q <= ready_d;
    end
  end

  // ****************************************
  // bus-side address, data and lanes
  // ****************************************
  // RQ12 loaded only at launch, held while stalled
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_q  <= '0;
      wdata_q <= '0;
      be_q    <= '0;
      off_q   <= '0;
    end else if (launch) begin
      // RQ13 aligned word address from encoder
      addr_q  <= lanes.word_addr;
      wdata_q <= lanes.lane_wdata;
      // RQ9 selects mark bytes read or written
      be_q    <= lanes.be;
      off_q   <= lanes.off;
    end
  end

  // ****************************************
  // user response
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_err_q   <= 1'b0;
    end else begin
      rsp_valid_q <= done || refuse;
      rsp_err_q   <= refuse;
    end
  end

  // ****************************************
  // read data capture
  // ****************************************
  // RQ4 held until the next read completes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= '0;
    end else if (got_read) begin
      rdata_q <= rd_shift;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // RQ1 byte address out
  assign o_address    = addr_q;
  // RQ4 read request
  assign o_read       = read_q;
  // RQ5 write request with data
  assign o_write      = write_q;
  assign o_writedata  = wdata_q;
  // RQ8 lane selects
  assign o_byteenable = be_q;
  assign o_cmd_ready  = ready_q;
  assign o_rsp_valid  = rsp_valid_q;
  assign o_rsp_err    = rsp_err_q;
  assign o_rsp_rdata  = rdata_q;
endmodule : mm_master_port

// [sim/mm_master_port_monitor.sv]
// assertion checker for the master port
`timescale 1ns/10ps
module mm_master_port_monitor #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
) (
  // watched ports
  input wire logic                i_clk,
  input wire logic                i_rst_n,
  input wire logic                i_cmd_valid,
  input wire logic                i_waitrequest,
  input wire logic                o_cmd_ready,
  input wire logic                o_rsp_valid,
  input wire logic                o_rsp_err,
  input wire logic                o_read,
  input wire logic                o_write,
  input wire logic [ADDR_W-1:0]   o_address,
  input wire logic [DATA_W-1:0]   o_writedata,
  input wire logic [DATA_W/8-1:0] o_byteenable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire req = o_read || o_write;
  excl_req_a: assert property (!(o_read && o_write))
    else $error("read and write both high");
  addr_align_a: assert property (req |-> (o_address % (DATA_W / 8)) == 0)
    else $error("unaligned address");
  lane_legal_a: assert property (req |-> o_byteenable inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf})
    else $error("illegal lane pattern");
  stall_hold_a: assert property (req && i_waitrequest |=>
    $stable({o_read, o_write, o_address, o_byteenable, o_writedata}))
    else $error("request changed while stalled");
  done_resp_a: assert property (req && !i_waitrequest |=> !req && o_rsp_valid && !o_rsp_err && o_cmd_ready)
    else $error("completion not answered");
  take_path_a: assert property (i_cmd_valid && o_cmd_ready |=> req != o_rsp_err)
    else $error("taken command neither issued nor refused");
  busy_req_a: assert property (req |-> !o_cmd_ready)
    else $error("ready during request");
  err_quiet_a: assert property (o_rsp_err |-> o_rsp_valid && !req)
    else $error("refusal with bus activity");
  cover property (o_read && !i_waitrequest);
  cover property (o_write && i_waitrequest ##1 o_write && !i_waitrequest);
  cover property (o_rsp_err);
endmodule : mm_master_port_monitor

// [sim/fabric_model.sv]
// fabric and slave memory model facing the master port
`timescale 1ns/10ps
module fabric_model (
  // clock, reset, stall mode
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_slow,
  // bus
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_address,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0]  i_byteenable,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest
);
  logic [31:0] mem_q [16];
  logic [31:0] last_q;
  logic [1:0]  wait_q;
  wire [3:0] word = i_address[5:2];
  wire       take = (i_read || i_write) && !o_waitrequest;
  assign o_waitrequest = i_slow && (i_read || i_write) && wait_q != 2'h2;
  // idle data never repeats the last word
  assign o_readdata = (i_read && take) ? mem_q[word] : ~last_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q <= 2'h0;
      last_q <= 32'h0;
      for (int i = 0; i < 16; i++) mem_q[i] <= 32'h0;
    end else begin
      last_q <= o_readdata;
      wait_q <= (take || !(i_read || i_write)) ? 2'h0 : wait_q + 2'h1;
      for (int l = 0; l < 4; l++) begin
        if (i_write && take && i_byteenable[l]) mem_q[word][8*l +: 8] <= i_writedata[8*l +: 8];
      end
    end
  end
endmodule : fabric_model

// [sim/mm_master_port_test.sv]
// self-checking bench for the master port
`timescale 1ns/10ps
module mm_master_port_test;
  typedef struct packed { logic err; logic [31:0] val; logic [31:0] msk; } note_t;
  logic        clk, rst_n, valid, wr, slow, ready, rv, re, rd, wt, stall;
  logic [31:0] addr, wdata, rdat, ad, wd, bus_rd, seed;
  logic [31:0] shadow [16];
  logic [2:0]  size;
  logic [3:0]  be;
  logic [1:0]  offs [10] = '{2'h0, 2'h0, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h0};
  logic [2:0]  sizes [10] = '{3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3};
  int          err_total, compares, cycles;
  note_t       notes [$];
  note_t       n;
  mm_master_port u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(valid), .i_cmd_write(wr),
    .i_cmd_addr(addr), .i_cmd_size(size), .i_cmd_wdata(wdata), .o_cmd_ready(ready), .o_rsp_valid(rv),
    .o_rsp_err(re), .o_rsp_rdata(rdat), .o_address(ad), .o_read(rd), .o_write(wt), .o_writedata(wd),
    .o_byteenable(be), .i_readdata(bus_rd), .i_waitrequest(stall));
  fabric_model u_fab (.i_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_read(rd), .i_write(wt),
    .i_address(ad), .i_writedata(wd), .i_byteenable(be), .o_readdata(bus_rd), .o_waitrequest(stall));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task report_and_stop();
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  // valid stays up between commands: back-to-back traffic
  task automatic send(input logic w, input logic [31:0] a, input logic [2:0] s, input logic [31:0] d);
    int    nb;
    int    off;
    note_t e;
    nb = 1 << s;
    off = a[1:0];
    e = '{1'b0, 32'h0, 32'h0};
    if (s > 3'h2 || (off % nb) != 0) begin
      e.err = 1'b1;
    end else if (w) begin
      for (int l = 0; l < nb; l++) shadow[a[5:2]][8*(off+l) +: 8] = d[8*l +: 8];
    end else begin
      e.msk = 32'hffff_ffff >> (32 - 8 * nb);
      e.val = (shadow[a[5:2]] >> (8 * off)) & e.msk;
    end
    notes.push_back(e);
    valid <= 1'b1;
    wr <= w;
    addr <= a;
    size <= s;
    wdata <= d;
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
  endtask : send
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (rv === 1'b1) begin
      n = notes.size() ? notes.pop_front() : note_t'{1'bx, 32'h0, 32'h0};
      compares++;
      if (re !== n.err || (rdat & n.msk) !== n.val) begin
        err_total++;
        $display("ERROR %0t response mismatch", $time);
      end
    end
    if (cycles == 5000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    {rst_n, valid, wr, slow, addr, size, wdata, err_total, compares, cycles} = '0;
    seed = 32'h0000_3927;
    foreach (shadow[i]) shadow[i] = 32'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    // every lane pattern written then read back, each pass ending in three refusals
    for (int k = 0; k < 20; k++) send(k < 10, 32'((k % 10) * 4 + offs[k % 10]), sizes[k % 10], rnd());
    // mid-run reset once the directed answers are in
    valid <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    if (rd !== 1'b0 || wt !== 1'b0 || rv !== 1'b0 || ready !== 1'b1) begin
      err_total++;
      $display("ERROR %0t outputs not idle in reset", $time);
    end
    compares++;
    foreach (shadow[i]) shadow[i] = 32'h0;
    rst_n <= 1'b1;
    repeat (80) begin
      seed = rnd();
      slow <= seed[8];
      send(seed[9], {26'h0, seed[5:0]}, seed[12:10], rnd());
    end
    valid <= 1'b0;
    repeat (20) @(posedge clk);
    if (notes.size() != 0) begin
      err_total++;
      $display("ERROR %0t responses missing", $time);
    end
    report_and_stop();
  end
endmodule : mm_master_port_test
bind mm_master_port mm_master_port_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid), .i_waitrequest(i_waitrequest), .o_cmd_ready(o_cmd_ready),
  .o_rsp_valid(o_rsp_valid), .o_rsp_err(o_rsp_err), .o_read(o_read), .o_write(o_write),
  .o_address(o_address), .o_writedata(o_writedata), .o_byteenable(o_byteenable));
